// file: verification/watchdog_timer_bench.sv
// Self-checking bench for the watchdog timer.
// Assumes the design package and the partner model are compiled first.
module watchdog_timer_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import wdt_pkg::*;
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_fail++; $display("wrong value %s exp %h got %h", nm, e, a); end end
	typedef struct {logic [31:0] d; logic l;} wdt_row_t;
	wdt_row_t    rows[4] = '{'{32'h0, 1'b1}, '{WDT_UNLOCK_KEY, 1'b0}, '{32'h1acc_e550, 1'b1}, '{WDT_UNLOCK_KEY, 1'b0}};
	logic        sys_clk, rst, wdtClkEn, debugHalt, stallEnable, intervalWr, controlWr, clearWr, guardWr, intMask;
	logic [31:0] intervalData, guardData, intervalReload, countValue, snap;
	logic [1:0]  controlData, watchdogControl;
	logic        rawStatus, maskedStatus, nmiOut, sysResetOut, locked;
	int          n_fail = 0, checked = 0, nmiCount, resetCount;
	watchdog_timer u_watchdog_timer (.sys_clk(sys_clk), .rst(rst), .wdtClkEn(wdtClkEn), .debugHalt(debugHalt),
		.stallEnable(stallEnable), .intervalWr(intervalWr), .intervalData(intervalData), .controlWr(controlWr),
		.controlData(controlData), .clearWr(clearWr), .guardWr(guardWr), .guardData(guardData), .intMask(intMask),
		.intervalReload(intervalReload), .countValue(countValue), .watchdogControl(watchdogControl),
		.rawStatus(rawStatus), .maskedStatus(maskedStatus), .nmiOut(nmiOut), .sysResetOut(sysResetOut),
		.locked(locked));
	wdt_sys_partner u_wdt_sys_partner (.sys_clk(sys_clk), .nmiOut(nmiOut), .sysResetOut(sysResetOut),
		.nmiCount(nmiCount), .resetCount(resetCount));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic stop_test();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	// One strobe: 0 interval, 1 control, 2 clear, 3 guard
	task automatic wr(input int k, input logic [31:0] d);
		@(posedge sys_clk);
		{intervalWr, controlWr, clearWr, guardWr} <= {k == 0, k == 1, k == 2, k == 3};
		{intervalData, guardData, controlData} <= {d, d, d[1:0]};
		@(posedge sys_clk);
		{intervalWr, controlWr, clearWr, guardWr} <= 4'h0;
		#1;
	endtask : wr
	task automatic waitFor(input logic rstSel, input int n);
		for (int j = 0; j < n && (rstSel ? sysResetOut : rawStatus) !== 1'b1; j++) begin
			@(posedge sys_clk);
			#1;
		end
	endtask : waitFor
	task automatic doReset();
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
	endtask : doReset
	initial begin
		repeat (3000) @(posedge sys_clk);
		n_fail++;
		stop_test();
	end
	initial begin
		{rst, wdtClkEn, intMask, debugHalt, stallEnable} = 5'h1c; // clock on first
		{intervalWr, controlWr, clearWr, guardWr, intervalData, guardData, controlData} = '0;
		doReset();
		`CHK("interval", WDT_LOAD_RST, intervalReload)
		`CHK("count", WDT_LOAD_RST, countValue)
		`CHK("control", WDT_CTL_RST, watchdogControl)
		`CHK("flags", 3'h0, {rawStatus, locked, sysResetOut})
		foreach (rows[i]) begin
			wr(3, rows[i].d);
			`CHK("locked", rows[i].l, locked)
		end
		$display("test 1 done");
		wr(0, 32'h8);
		`CHK("interval", 32'h8, intervalReload)
		wr(1, 32'h2);
		`CHK("control", 2'h2, watchdogControl)
		wr(1, 32'h3);
		wr(1, 32'h0);
		`CHK("control", 2'h3, watchdogControl)
		waitFor(0, 40);
		`CHK("raw", 2'h3, {rawStatus, nmiOut})
		waitFor(1, 40);
		`CHK("sysreset", 1'b1, sysResetOut)
		doReset();
		`CHK("resets", 1, resetCount)
		`CHK("nmis", 1, nmiCount)
		`CHK("control", 2'h0, watchdogControl)
		$display("test 2 done");
		@(posedge sys_clk);
		intMask <= 1'b0;
		wr(0, 32'h6);
		wr(1, 32'h1);
		waitFor(0, 30);
		`CHK("status", 2'h2, {rawStatus, maskedStatus})
		wr(0, 32'h20);
		`CHK("raw", 1'b1, rawStatus)
		wr(2, 32'h0);
		`CHK("raw", 1'b0, rawStatus)
		waitFor(1, 80);
		`CHK("sysreset", 1'b0, sysResetOut)
		$display("test 3 done");
		for (int i = 0; i < 2; i++) begin
			@(posedge sys_clk);
			{stallEnable, debugHalt, wdtClkEn} <= {1'b1, i == 0, i == 0};
			repeat (3) @(posedge sys_clk);
			#1;
			snap = countValue;
			repeat (5) @(posedge sys_clk);
			#1;
			`CHK("frozen", snap, countValue)
		end
		@(posedge sys_clk);
		{debugHalt, wdtClkEn} <= 2'h1;
		wr(3, 32'h1);
		wr(0, 32'h9);
		`CHK("interval", 32'h20, intervalReload)
		wr(3, WDT_UNLOCK_KEY);
		wr(2, 32'h0);
		`CHK("raw", 1'b0, rawStatus)
		wr(0, 32'h0);
		waitFor(0, 4);
		`CHK("raw", 1'b1, rawStatus)
		$display("test 4 done");
		stop_test();
	end
endmodule : watchdog_timer_bench

// file: verification/wdt_props.sv
// Port checker for the watchdog timer, bound into the design.
// Assumes one clock with a synchronous active-high reset.
module wdt_props
	import wdt_pkg::*;
#(
	parameter int CNT_W = 32
) (
	input wire logic                 sys_clk,         // Clock
	input wire logic                 rst,             // Reset
	input wire logic                 intervalWr,      // Interval strobe
	input wire logic [CNT_W-1:0]     intervalData,    // Interval data
	input wire logic                 clearWr,         // Clear strobe
	input wire logic                 guardWr,         // Guard strobe
	input wire logic [31:0]          guardData,       // Guard data
	input wire logic                 intMask,         // Mask
	input wire logic [CNT_W-1:0]     intervalReload,  // Interval out
	input wire logic [CNT_W-1:0]     countValue,      // Count out
	input wire logic [WDT_CTL_W-1:0] watchdogControl, // Control out
	input wire logic                 rawStatus,       // Raw status
	input wire logic                 maskedStatus,    // Masked status
	input wire logic                 sysResetOut,     // Reset request
	input wire logic                 locked           // Lock state
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_ctl_lock:
		assert property (watchdogControl[0] |=> $stable(watchdogControl)) else $error("control moved once armed");
	a_mask_block:
		assert property (!intMask && $past(!intMask) |-> !maskedStatus) else $error("masked status leaked");
	a_raw_hold:
		assert property (rawStatus && !clearWr |=> rawStatus) else $error("raw status dropped");
	a_clear_drop:
		assert property (clearWr && !locked && countValue > 32'h10 && intervalReload > 32'h10 |=> !rawStatus)
			else $error("clear ignored");
	a_rst_len:
		assert property ($rose(sysResetOut) |-> sysResetOut[*4] ##1 !sysResetOut) else $error("reset pulse length");
	a_rst_cause:
		assert property ($rose(sysResetOut) |-> watchdogControl[1] && $past(rawStatus)) else $error("reset w/o cause");
	a_guard_lock:
		assert property (guardWr && guardData != WDT_UNLOCK_KEY |=> locked) else $error("guard write did not lock");
	a_key_only:
		assert property (locked && !(guardWr && guardData == WDT_UNLOCK_KEY) |=> locked) else $error("lock lost");
	a_wr_locked:
		assert property (locked && !guardWr && intervalWr |=> $stable(intervalReload)) else $error("locked write taken");
	a_wr_load:
		assert property (intervalWr && !locked |=> intervalReload == $past(intervalData)) else $error("interval lost");
endmodule : wdt_props

bind watchdog_timer wdt_props #(.CNT_W(CNT_W)) u_wdt_props (.sys_clk(sys_clk), .rst(rst), .intervalWr(intervalWr),
	.intervalData(intervalData), .clearWr(clearWr), .guardWr(guardWr), .guardData(guardData), .intMask(intMask),
	.intervalReload(intervalReload), .countValue(countValue), .watchdogControl(watchdogControl),
	.rawStatus(rawStatus), .maskedStatus(maskedStatus), .sysResetOut(sysResetOut), .locked(locked));

// file: verification/wdt_sys_partner.sv
// Processor interrupt input and system reset generator model.
// Assumes both requests are synchronous to sys_clk; counts survive reset.
module wdt_sys_partner (
	input  wire logic sys_clk,     // Clock
	input  wire logic nmiOut,      // NMI request
	input  wire logic sysResetOut, // Reset request
	output int        nmiCount,    // NMIs taken
	output int        resetCount   // Resets taken
);
	timeunit 1ns;
	timeprecision 1ns;
	logic nmiLast = 1'b0;
	logic resetLast = 1'b0;
	always @(posedge sys_clk) begin
		nmiCount <= nmiCount + int'(nmiOut && !nmiLast);
		resetCount <= resetCount + int'(sysResetOut && !resetLast);
		nmiLast <= nmiOut;
		resetLast <= sysResetOut;
	end
	initial begin
		nmiCount = 0;
		resetCount = 0;
	end
endmodule : wdt_sys_partner

// file: verilog/watchdog_timer.sv
// Watchdog timer: down counter, time-out interrupt, second time-out reset.
// Assumes register writes arrive as one-cycle strobes with data, synchronous
// to sys_clk; the surrounding clock gating drives wdtClkEn.

// Overview of operation
// - 32-bit down counter loaded from interval
// - Counter advances only with watchdog clock enable
// - Debug halt freezes counter when stall enabled
// - First zero after enabling raises time-out
// - Arming starts count and enables interrupt
// - Reload from interval after first time-out
// - Second zero while pending asserts reset
// - Clear before second zero reloads and resumes
// - Interval write loads counter immediately
// - Interval write leaves pending interrupt set
// - Re-arming preloads counter from interval
// - Arm bit starts and locks control
// - Any non-key guard write locks interval, control, clear
// - Only exact key or reset unlocks registers
// - Mask keeps time-out from processor
// - Time-out goes out as NMI or reset
// - Zero interval raises interrupt immediately
// - Control lock cleared only by reset
// - Control bit1 reset enable, bit0 arm
// - Raw status visible even when masked
module watchdog_timer #(
	parameter int CNT_W = wdt_pkg::WDT_CNT_W
) (
	input  wire logic                       sys_clk,         // 20 MHz system clock
	input  wire logic                       rst,             // Synchronous reset, active high
	input  wire logic                       wdtClkEn,        // Watchdog clock enable from gating
	input  wire logic                       debugHalt,       // Processor halted in debug
	input  wire logic                       stallEnable,     // Freeze counter during debug halt
	input  wire logic                       intervalWr,      // Interval reload write strobe
	input  wire logic [CNT_W-1:0]           intervalData,    // Interval reload write data
	input  wire logic                       controlWr,       // Watchdog control write strobe
	input  wire logic [wdt_pkg::WDT_CTL_W-1:0] controlData,  // Watchdog control write data
	input  wire logic                       clearWr,         // Interrupt clear write strobe
	input  wire logic                       guardWr,         // Access guard write strobe
	input  wire logic [31:0]                guardData,       // Access guard write data
	input  wire logic                       intMask,         // 1 lets time-out reach processor
	output logic      [CNT_W-1:0]           intervalReload,  // Interval reload readback
	output logic      [CNT_W-1:0]           countValue,      // Current counter value
	output logic      [wdt_pkg::WDT_CTL_W-1:0] watchdogControl, // Control readback
	output logic                            rawStatus,       // Raw time-out status
	output logic                            maskedStatus,    // Masked time-out status
	output logic                            nmiOut,          // Nonmaskable interrupt to processor
	output logic                            sysResetOut,     // System reset request
	output logic                            locked           // Access guard lock state
);

	import wdt_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	wdt_state_t       state;
	logic [CNT_W-1:0] count;
	logic             atZero;
	logic             ctlArm;
	logic             ctlResEn;
	logic             wrOpen;
	logic             intervalDo;
	logic             controlDo;
	logic             clearDo;
	logic             armRise;
	logic             loadReq;
	logic             counterLoad;
	logic [CNT_W-1:0] counterLoadValue;
	logic             run;
	logic             zeroLoad;
	logic             timeout;
	logic [2:0]       rstCnt;
	logic             next_locked;
	wdt_state_t       next_state;
	logic             next_rawStatus;
	logic             pendingIrq;
	logic             resetFire;
	logic [2:0]       next_rstCnt;
	logic             next_sysResetOut;

	// ----------------------------------------
	// Write gating
	// ----------------------------------------
	// guard blocks writes
	assign wrOpen     = !locked;
	assign intervalDo = intervalWr && wrOpen;
	assign controlDo  = controlWr && wrOpen && !ctlArm;
	assign clearDo    = clearWr && wrOpen;
	assign armRise    = controlDo && controlData[WDT_CTL_ARM_BIT];

	// The guard itself is never gated, otherwise a lock could not be undone.
	always_comb begin
		next_locked = locked;
		if (guardWr) begin
			next_locked = (guardData != WDT_UNLOCK_KEY);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			locked <= 1'b0;
		end else begin
			locked <= next_locked;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// interval write sets interval and also reloads counter
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			intervalReload <= WDT_LOAD_RST[CNT_W-1:0];
		end else if (intervalDo) begin
			intervalReload <= intervalData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctlArm   <= WDT_CTL_RST[WDT_CTL_ARM_BIT];
			ctlResEn <= WDT_CTL_RST[WDT_CTL_RESET_OUTPUT_ENABLE_BIT];
		end else if (controlDo) begin
			ctlArm   <= controlData[WDT_CTL_ARM_BIT];
			ctlResEn <= controlData[WDT_CTL_RESET_OUTPUT_ENABLE_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			watchdogControl <= WDT_CTL_RST;
		end else if (controlDo) begin
			watchdogControl <= controlData;
		end
	end

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// clock enable gates count
	assign run = ctlArm && wdtClkEn && !(stallEnable && debugHalt);

	// a zero interval times out at once
	assign zeroLoad = (intervalDo && intervalData == '0) || (armRise && intervalReload == '0);

	assign loadReq          = intervalDo || armRise || clearDo;
	assign counterLoad      = loadReq || atZero;
	assign counterLoadValue = intervalDo ? intervalData : intervalReload;

	wdt_down_counter #(
		.W(CNT_W)
	) u_counter (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.rstValue  (WDT_LOAD_RST[CNT_W-1:0]),
		.load      (counterLoad),
		.loadValue (counterLoadValue),
		.run       (run),
		.count     (count),
		.atZero    (atZero)
	);

	// The reload on a zero happens on the same edge, so a zero is seen once.
	// A zero that meets a software load still counts: the event wins.
	assign timeout = atZero || (zeroLoad && (ctlArm || armRise));

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			countValue <= WDT_LOAD_RST[CNT_W-1:0];
		end else begin
			countValue <= count;
		end
	end

	// ----------------------------------------
	// Time-out sequencing
	// ----------------------------------------
	// Pending lasts from a time-out until a clear. A time-out in the clear's
	// own cycle wins, so a fresh zero is never lost to a late clear.
	always_comb begin
		next_state = state;
		unique case (state)
			WDT_IDLE: begin
				// Arming onto a zero interval times out at once
				if (armRise) begin
					next_state = timeout ? WDT_SECOND : WDT_FIRST;
				end
			end
			WDT_FIRST: begin
				if (timeout) begin
					next_state = WDT_SECOND;
				end
			end
			WDT_SECOND: begin
				if (clearDo && !timeout) begin
					next_state = WDT_FIRST;
				end
			end
			default: begin
				next_state = WDT_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= WDT_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// Interrupt status
	// ----------------------------------------
	// Set wins over clear, matching the sequencer above.
	always_comb begin
		next_rawStatus = rawStatus;
		if (timeout) begin
			next_rawStatus = 1'b1;
		end else if (clearDo) begin
			next_rawStatus = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rawStatus <= 1'b0;
		end else begin
			rawStatus <= next_rawStatus;
		end
	end

	// Masked copies follow the next raw value, so the processor sees the
	// time-out on the same edge as the raw flag rises.
	assign pendingIrq = next_rawStatus && intMask;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			maskedStatus <= 1'b0;
		end else begin
			maskedStatus <= pendingIrq;
		end
	end

	// delivered as NMI
	// Own flop, so the interrupt line does not share a driver with readback.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			nmiOut <= 1'b0;
		end else begin
			nmiOut <= pendingIrq;
		end
	end

	// ----------------------------------------
	// System reset pulse
	// ----------------------------------------
	// needs reset enable
	assign resetFire = (state == WDT_SECOND) && timeout && ctlResEn;

	// A fixed-length pulse; the reset generator is expected to stretch it.
	// A fire during the pulse restarts the length count.
	always_comb begin
		next_rstCnt      = rstCnt;
		next_sysResetOut = sysResetOut;
		if (resetFire) begin
			next_rstCnt      = 3'(WDT_RST_PULSE_CYC - 1);
			next_sysResetOut = 1'b1;
		end else if (rstCnt != 3'h0) begin
			next_rstCnt      = rstCnt - 3'h1;
		end else begin
			next_sysResetOut = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rstCnt      <= 3'h0;
			sysResetOut <= 1'b0;
		end else begin
			rstCnt      <= next_rstCnt;
			sysResetOut <= next_sysResetOut;
		end
	end

endmodule : watchdog_timer

// file: verilog/wdt_down_counter.sv
// Loadable 32-bit down counter with a hold input.
// Assumes the load request has priority over counting and hold.
module wdt_down_counter #(
	parameter int W = 32
) (
	input  wire logic         sys_clk,   // System clock
	input  wire logic         rst,       // Synchronous reset
	input  wire logic [W-1:0] rstValue,  // Value taken at reset
	input  wire logic         load,      // Load request
	input  wire logic [W-1:0] loadValue, // Value to load
	input  wire logic         run,       // Decrement enable
	output logic      [W-1:0] count,     // Current count
	output logic              atZero     // Count reaches zero this cycle
);

	// The load request is left out here on purpose: the owner feeds atZero
	// back into load, and folding load in would close a combinational loop.
	assign atZero = run && (count == {{(W-1){1'b0}}, 1'b1});

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			count <= rstValue;
		end else if (load) begin
			count <= loadValue;
		end else if (run && count != '0) begin
			count <= count - {{(W-1){1'b0}}, 1'b1};
		end
	end

endmodule : wdt_down_counter

// file: verilog/wdt_pkg.sv
// Constants shared by the watchdog timer design.
// Assumes one 20 MHz system clock and a synchronous active-high reset.
package wdt_pkg;

	// ----------------------------------------
	// Widths and reset values
	// ----------------------------------------
	localparam int          WDT_CNT_W      = 32;
	localparam logic [31:0] WDT_LOAD_RST   = 32'hffff_ffff;
	localparam logic [31:0] WDT_UNLOCK_KEY = 32'h1acc_e551;
	localparam logic [31:0] WDT_ZERO       = 32'h0000_0000;

	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int WDT_CTL_ARM_BIT   = 0;
	localparam int WDT_CTL_RESET_OUTPUT_ENABLE_BIT = 1;
	localparam int WDT_CTL_W         = 2;
	localparam logic [1:0] WDT_CTL_RST = 2'h0;

	// ----------------------------------------
	// Reset pulse length in system clocks
	// ----------------------------------------
	localparam int WDT_RST_PULSE_CYC = 4;

	// Time-out sequencing: idle, counting to first zero, waiting for second
	typedef enum logic [1:0] {
		WDT_IDLE   = 2'b00,
		WDT_FIRST  = 2'b01,
		WDT_SECOND = 2'b10
	} wdt_state_t;

endpackage : wdt_pkg
